// file: common/pibc_cfg.svh
// timing counts, jumper defaults and vector layout for the bus interrupt control
// assumes a 40 MHz system clock
`ifndef PIBC_CFG_SVH
`define PIBC_CFG_SVH
`define PIBC_CLK_PERIOD_NS 25
`define PIBC_WIN_NS 100
`define PIBC_WIN_CYC ((`PIBC_WIN_NS + `PIBC_CLK_PERIOD_NS - 1) / `PIBC_CLK_PERIOD_NS)
`define PIBC_NSRC 6
`define PIBC_LVL_A 3'h6
`define PIBC_LVL_B 3'h5
`define PIBC_LVL_C 3'h4
`define PIBC_LVL_D 3'h4
`define PIBC_LVL_E 3'h4
`define PIBC_LVL_F 3'h4
`define PIBC_VEC_BASE 7'h30
`define PIBC_VEC_LSB 2
`define PIBC_VEC_MSB 8
`endif

// file: common/pibc_pkg.sv
// types shared by the bus interrupt control
// assumes pibc_cfg.svh in the include path
`default_nettype none
package pibc_pkg;
   typedef struct packed {
      logic [3:0] br;
      logic [3:0] bg;
   } pibc_arb_t;
   typedef struct packed {
      logic sack;
      logic bbsy;
      logic intr;
      logic [6:0] vec;
      logic vec_oe;
   } pibc_bus_out_t;
   typedef enum logic [3:0] {
      PIBC_IDLE = 4'h1,
      PIBC_WAIT = 4'h2,
      PIBC_SCAN = 4'h4,
      PIBC_PASS = 4'h8
   } pibc_chain_t;
endpackage
`default_nettype wire

// file: hdl/pibc_stage.sv
// one position of the grant chain: 100 ns window, claim check, pass on
// assumes synchronous inputs from the chain controller
`default_nettype none
module pibc_stage #(
   parameter int WIN = 4
) (
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_grant_in,
   input wire logic i_latched,
   input wire logic i_claimed,
   output logic o_grant_out,
   output logic o_claim
);
   import pibc_pkg::*;
   pibc_chain_t st_r;
   logic [7:0] cnt_r;
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         st_r <= PIBC_IDLE;
         cnt_r <= 8'h00;
      end else begin
         case (st_r)
            PIBC_IDLE: begin
               if (i_grant_in && !i_claimed) begin
                  st_r <= PIBC_SCAN;
                  cnt_r <= 8'h00;
               end
            end
            PIBC_SCAN: begin
               if (!i_grant_in) st_r <= PIBC_IDLE;
               else if (i_latched) st_r <= PIBC_WAIT;
               else if (cnt_r == 8'(WIN - 1)) st_r <= PIBC_PASS;
               else cnt_r <= cnt_r + 8'h01;
            end
            PIBC_PASS, PIBC_WAIT: begin
               if (!i_grant_in) st_r <= PIBC_IDLE;
            end
            default: st_r <= PIBC_IDLE;
         endcase
      end
   end
   // a claim in one position blocks the grant from going further
   assign o_grant_out = (st_r == PIBC_PASS) && i_grant_in && !i_claimed;
   assign o_claim = (st_r == PIBC_SCAN) && i_grant_in && i_latched && !i_claimed;
endmodule
`default_nettype wire

// file: hdl/pibc_sync.sv
// two flip-flop synchroniser for a bus of levels
// assumes inputs are asynchronous to the clock
`default_nettype none
module pibc_sync #(
   parameter int W = 1
) (
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic [W-1:0] i_d,
   output logic [W-1:0] o_q
);
   logic [W-1:0] s1_r;
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         s1_r <= '0;
         o_q <= '0;
      end else begin
         s1_r <= i_d;
         o_q <= s1_r;
      end
   end
endmodule
`default_nettype wire

// file: hdl/pibc_top.sv
// bus interrupt and priority control for six internal option sources
// assumes bus grants and slave sync come from outside (synchronised here);
// source requests come from same-clock option logic
`default_nettype none
`include "pibc_cfg.svh"
module pibc_top #(
   parameter int NSRC = `PIBC_NSRC,
   parameter logic [2:0] LVL_A = `PIBC_LVL_A,
   parameter logic [2:0] LVL_B = `PIBC_LVL_B,
   parameter logic [2:0] LVL_C = `PIBC_LVL_C,
   parameter logic [2:0] LVL_D = `PIBC_LVL_D,
   parameter logic [2:0] LVL_E = `PIBC_LVL_E,
   parameter logic [2:0] LVL_F = `PIBC_LVL_F,
   parameter logic [6:0] VEC_BASE = `PIBC_VEC_BASE
) (
   // clock and reset
   input wire logic I_CLK_SYS,
   input wire logic I_RESETN,
   // system initialize from the bus
   input wire logic I_INIT,
   // option sources
   input wire logic [NSRC-1:0] I_SRC_REQ,
   output logic [NSRC-1:0] O_SRC_DONE,
   // arbitration lines, levels 4..7
   input wire logic [3:0] I_BG,
   input wire logic I_SSYN,
   input wire logic I_BBSY_IN,
   output pibc_pkg::pibc_arb_t O_ARB,
   output pibc_pkg::pibc_bus_out_t O_BUS
);
   import pibc_pkg::*;
   localparam int WIN = `PIBC_WIN_CYC;
   localparam logic [2:0] LVL [0:5] = '{LVL_A, LVL_B, LVL_C, LVL_D, LVL_E, LVL_F};

   logic [3:0] bg_s;
   logic ssyn_s, init_s, bbsy_other_s;
   logic [NSRC-1:0] req_latch_r, hold_r;
   logic claim_r, master_r, end_r, vec_phase;
   logic grant_qualify, request_latch_strobe, hold_load_strobe;
   logic [7:0] dly_r;
   logic dly_run_r, ssyn_d_r;
   logic [NSRC:0] chain [0:3];
   logic [NSRC-1:0] claim_v [0:3];
   logic [NSRC-1:0] claim_any;
   logic [3:0] br_v;

   pibc_sync #(.W(7)) u_sync (
      .i_clk(I_CLK_SYS),
      .i_resetn(I_RESETN),
      .i_d({I_BG, I_SSYN, I_INIT, I_BBSY_IN}),
      .o_q({bg_s, ssyn_s, init_s, bbsy_other_s})
   );

   function automatic logic [1:0] lvl_idx(input logic [2:0] l);
      lvl_idx = l[1:0];
   endfunction

   // busy: hold latch non-empty means an interrupt is in process
   assign request_latch_strobe = (hold_r == '0) && !claim_r && !end_r && !dly_run_r;

   always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
      if (!I_RESETN) req_latch_r <= '0;
      else if (init_s) req_latch_r <= '0;
      else if (end_r && !ssyn_d_r) req_latch_r <= '0;
      else if (request_latch_strobe) req_latch_r <= I_SRC_REQ;
   end

   // bus requests per level through the jumper socket of each source
   always_comb begin
      br_v = 4'h0;
      for (int i = 0; i < NSRC; i++) begin
         if (req_latch_r[i] && !master_r && !claim_r && !init_s)
            br_v[lvl_idx(LVL[i])] = 1'b1;
      end
   end

   // one chain per grant level; each source sits on the chain of its level, in order A..F
   // so the lower-lettered source is nearer the processor
   genvar g, s;
   generate
      for (g = 0; g < 4; g++) begin : g_lvl
         assign chain[g][0] = bg_s[g];
         for (s = 0; s < NSRC; s++) begin : g_pos
            logic on_lvl, gout, clm;
            assign on_lvl = (lvl_idx(LVL[s]) == 2'(g));
            pibc_stage #(.WIN(WIN)) u_stage (
               .i_clk(I_CLK_SYS),
               .i_resetn(I_RESETN),
               .i_grant_in(on_lvl && chain[g][s]),
               .i_latched(req_latch_r[s]),
               .i_claimed(claim_r),
               .o_grant_out(gout),
               .o_claim(clm)
            );
            // a position off this level passes the grant straight through
            assign chain[g][s+1] = on_lvl ? gout : chain[g][s];
            assign claim_v[g][s] = clm;
         end
      end
   endgenerate
   // the whole struct has one driver; mixing procedural and continuous writes is illegal
   assign O_ARB = '{br: br_v,
                    bg: {chain[3][NSRC], chain[2][NSRC], chain[1][NSRC], chain[0][NSRC]}};
   assign claim_any = claim_v[0] | claim_v[1] | claim_v[2] | claim_v[3];
   assign hold_load_strobe = (claim_any != '0) && !claim_r;

   // claim flop, cleared when the served source drops its request
   always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
      if (!I_RESETN) claim_r <= 1'b0;
      else if (init_s) claim_r <= 1'b0;
      else if (claim_r && ((I_SRC_REQ & hold_r) == '0) && end_r) claim_r <= 1'b0;
      else if (hold_load_strobe) claim_r <= 1'b1;
   end

   always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
      if (!I_RESETN) hold_r <= '0;
      else if (init_s) hold_r <= '0;
      else if (hold_load_strobe) hold_r <= claim_any;
      else if (dly_run_r && dly_r == 8'(WIN - 1)) hold_r <= '0;
   end

   assign grant_qualify = !bbsy_other_s && !master_r;

   always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
      if (!I_RESETN) master_r <= 1'b0;
      else if (init_s) master_r <= 1'b0;
      else if (master_r && ((I_SRC_REQ & hold_r) == '0) && end_r) master_r <= 1'b0;
      else if (claim_r && !end_r && bg_s == 4'h0 && grant_qualify) master_r <= 1'b1;
   end

   assign vec_phase = claim_r && master_r;

   // end flop: set on slave sync in the vector phase, cleared when it goes away
   always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
      if (!I_RESETN) begin
         end_r <= 1'b0;
         ssyn_d_r <= 1'b0;
      end else if (init_s) begin
         end_r <= 1'b0;
         ssyn_d_r <= 1'b0;
      end else begin
         ssyn_d_r <= end_r;
         if (ssyn_s && vec_phase) end_r <= 1'b1;
         else if (!ssyn_s) end_r <= 1'b0;
      end
   end

   // 100 ns after end clears, the hold latch is emptied
   always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
      if (!I_RESETN) begin
         dly_run_r <= 1'b0;
         dly_r <= 8'h00;
      end else if (init_s) begin
         dly_run_r <= 1'b0;
         dly_r <= 8'h00;
      end else if (end_r && !ssyn_s) begin
         dly_run_r <= 1'b1;
         dly_r <= 8'h00;
      end else if (dly_run_r) begin
         if (dly_r == 8'(WIN - 1)) dly_run_r <= 1'b0;
         else dly_r <= dly_r + 8'h01;
      end
   end

   // vector base + 4 per source, in D08:D02 units that is +1 per source
   logic [6:0] vec_nxt;
   always_comb begin
      vec_nxt = VEC_BASE;
      for (int i = 0; i < NSRC; i++) begin
         if (hold_r[i]) vec_nxt = VEC_BASE + 7'(i);
      end
   end

   // data outputs are registered; slave sync sampling tolerates the one-cycle lag
   always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
      if (!I_RESETN) begin
         O_BUS <= '0;
         O_SRC_DONE <= '0;
      end else if (init_s) begin
         O_BUS <= '0;
         O_SRC_DONE <= '0;
      end else begin
         O_BUS.sack <= claim_r && !master_r;
         O_BUS.bbsy <= master_r;
         O_BUS.intr <= vec_phase && !end_r;
         O_BUS.vec <= vec_nxt;
         O_BUS.vec_oe <= vec_phase;
         O_SRC_DONE <= end_r ? hold_r : '0;
      end
   end
endmodule
`default_nettype wire

// file: tb/peripheral_interrupt_bus_control_test.sv
// self-checking bench for the bus interrupt control
// assumes default jumpers; sources are modelled here, processor in pibc_cpu_model
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
   $display("unexpected %s expected %h seen %h", nm, e, g); end end
`define WT(c) while (!(c)) @(negedge clk);
module peripheral_interrupt_bus_control_test;
   timeunit 1ns;
   timeprecision 1ps;
   import pibc_pkg::*;
   localparam logic [2:0] LVL [6] = '{3'h6, 3'h5, 3'h4, 3'h4, 3'h4, 3'h4};
   logic clk = 1'b0, rstn = 1'b0, init = 1'b0, ssyn;
   logic [5:0] req = '0, done;
   logic [3:0] bg;
   pibc_arb_t arb;
   pibc_bus_out_t bus;
   int n_checks = 0, n_mismatch = 0, cyc = 0;
   always #12.5 clk = ~clk;
   pibc_top i_dut (.I_CLK_SYS(clk), .I_RESETN(rstn), .I_INIT(init), .I_SRC_REQ(req),
      .O_SRC_DONE(done), .I_BG(bg), .I_SSYN(ssyn), .I_BBSY_IN(1'b0), .O_ARB(arb), .O_BUS(bus));
   pibc_cpu_model i_cpu (.i_clk(clk), .i_arb(arb), .i_bus(bus), .o_bg(bg), .o_ssyn(ssyn));
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // one interrupt of source i, from request to ready again
   task automatic serve(input int i);
      `WT(bus.intr)
      `CHK("vector", 7'h30 + 7'(i), bus.vec)
      `WT(done != 6'h00)
      `CHK("done", 6'(1 << i), done)
      @(posedge clk) req[i] <= 1'b0;
      `WT(!ssyn)
      `CHK("bus busy", 1'b0, bus.bbsy)
      repeat (10) @(posedge clk);
   endtask
   task automatic t_levels();
      for (int i = 0; i < 6; i++) begin
         @(posedge clk) req[i] <= 1'b1;
         `WT(arb.br != 4'h0)
         `CHK("level", 4'(1 << (LVL[i] - 3'h4)), arb.br)
         serve(i);
      end
   endtask
   // four sources on the shared level at once, slow processor
   task automatic t_shared();
      i_cpu.lat = 20;
      @(posedge clk) req <= 6'h3c;
      for (int i = 2; i < 6; i++) serve(i);
      i_cpu.lat = 2;
   endtask
   task automatic t_init();
      @(posedge clk) req <= 6'h01;
      `WT(bus.intr)
      @(posedge clk) begin
         init <= 1'b1;
         req <= 6'h00;
      end
      repeat (6) @(negedge clk);
      `CHK("busy after init", 1'b0, bus.bbsy)
      `CHK("request after init", 4'h0, arb.br)
      @(posedge clk) init <= 1'b0;
      repeat (40) @(posedge clk);
      `CHK("done after init", 6'h00, done)
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_mismatch++;
         print_verdict();
      end
   end
   initial begin
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      repeat (4) @(posedge clk);
      t_levels();
      t_shared();
      t_init();
      t_levels();
      print_verdict();
   end
endmodule
`default_nettype wire

// file: tb/pibc_checker.sv
// port assertions for the bus interrupt control
// assumes bound into pibc_top, one clock domain
`default_nettype none
module pibc_checker #(
   parameter int NSRC = 6,
   parameter logic [6:0] VEC_BASE = 7'h30
) (
   input wire logic I_CLK_SYS,
   input wire logic I_RESETN,
   input wire logic I_INIT,
   input wire logic [NSRC-1:0] I_SRC_REQ,
   input wire logic [NSRC-1:0] O_SRC_DONE,
   input wire logic [3:0] I_BG,
   input wire logic I_SSYN,
   input wire pibc_pkg::pibc_arb_t O_ARB,
   input wire pibc_pkg::pibc_bus_out_t O_BUS
);
   timeunit 1ns;
   timeprecision 1ps;
   import pibc_pkg::*;
   default clocking @(posedge I_CLK_SYS); endclocking
   default disable iff (!I_RESETN);
   a_busy_with_intr: assert property (
      O_BUS.bbsy |-> O_BUS.vec_oe && (O_BUS.intr || O_SRC_DONE != '0))
      else $error("busy without intr or vector");
   a_vec_needs_master: assert property (
      O_BUS.vec_oe |-> O_BUS.bbsy && !O_BUS.sack) else $error("vector driven without master");
   a_vec_in_range: assert property (
      O_BUS.vec_oe |-> O_BUS.vec >= VEC_BASE && O_BUS.vec <= VEC_BASE + 7'h05)
      else $error("vector outside table");
   a_claim_blocks: assert property (
      O_BUS.sack |-> O_ARB.bg == 4'h0) else $error("grant passed on while claimed");
   a_master_waits: assert property (
      O_BUS.sack && (I_BG != 4'h0) |=> !O_BUS.bbsy) else $error("master before grant drop");
   a_done_after_ssyn: assert property (
      $rose(|O_SRC_DONE) |-> I_SSYN && $past(I_SSYN) && $onehot(O_SRC_DONE))
      else $error("done without slave sync");
   a_busy_release: assert property (
      $fell(|I_SRC_REQ) && O_BUS.bbsy |-> ##[1:3] !O_BUS.bbsy) else $error("busy held");
   a_init_clears: assert property (
      I_INIT [*4] |-> O_ARB.br == 4'h0 && !O_BUS.sack && !O_BUS.bbsy && O_SRC_DONE == '0)
      else $error("initialize left outputs set");
endmodule
bind pibc_top pibc_checker #(.NSRC(NSRC), .VEC_BASE(VEC_BASE)) i_chk (
   .I_CLK_SYS(I_CLK_SYS), .I_RESETN(I_RESETN), .I_INIT(I_INIT), .I_SRC_REQ(I_SRC_REQ),
   .O_SRC_DONE(O_SRC_DONE), .I_BG(I_BG), .I_SSYN(I_SSYN), .O_ARB(O_ARB), .O_BUS(O_BUS));
`default_nettype wire

// file: tb/pibc_cpu_model.sv
// processor and arbiter on the far side of the bus interrupt control
// assumes lat is set by the bench for prompt or slow answers
`default_nettype none
module pibc_cpu_model (
   input wire logic i_clk,
   input wire pibc_pkg::pibc_arb_t i_arb,
   input wire pibc_pkg::pibc_bus_out_t i_bus,
   output logic [3:0] o_bg,
   output logic o_ssyn
);
   timeunit 1ns;
   timeprecision 1ps;
   import pibc_pkg::*;
   int lat = 2;
   initial begin
      o_bg = 4'h0;
      o_ssyn = 1'b0;
      forever begin
         @(posedge i_clk);
         if (i_arb.br != 4'h0) begin
            repeat (lat) @(posedge i_clk);
            // grant only the highest pending level
            o_bg <= i_arb.br[3] ? 4'h8 : i_arb.br[2] ? 4'h4 : i_arb.br[1] ? 4'h2 : i_arb.br;
            for (int k = 0; k < 60 && !i_bus.sack; k++) @(posedge i_clk);
            o_bg <= 4'h0;
            for (int k = 0; k < 60 && !i_bus.intr; k++) @(posedge i_clk);
            if (i_bus.intr) begin
               o_ssyn <= 1'b1;
               for (int k = 0; k < 300 && i_bus.bbsy; k++) @(posedge i_clk);
               repeat (lat) @(posedge i_clk);
               o_ssyn <= 1'b0;
            end
         end
      end
   end
endmodule
`default_nettype wire
